//--- logic/acq_qualifier.sv
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
// How it works
// - Transitional mode compares the monitored group with its previous sample.
// - Transitional mode stores only when a monitored signal changed.
// - Conditional mode decides by a combinational function evaluated every cycle.
// - Conditional mode stores exactly in the cycles where the condition is true.
// - Each signal test is ignore, low, high, falling, rising or either edge.
// - AND type needs every enabled signal test to hold.
// - Advanced type applies relational operators to storage-enabled signals.
// - Signals not storage-enabled never take part in the condition.
// - With discontinuity recording on, a store after suppressed cycles is marked.
// - Continuous mode, the default, stores every cycle.
// - Input-port mode stores when the qualifier input is high.
// - Trigger matching runs regardless of the store decision.
// - Any mode but continuous needs a non-segmented buffer.
module acq_qualifier (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [acq_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sample_valid_in,
  input wire logic [acq_pkg::SIG_W-1:0] sample_in,
  output logic sample_ready_out,
  input wire logic qual_in,
  output logic trigger_out,
  output logic mem_valid_out,
  input wire logic mem_ready_in,
  output logic [acq_pkg::ADDR_W-1:0] mem_addr_out,
  output logic [acq_pkg::SIG_W-1:0] mem_data_out,
  output logic mem_disc_out
);
  import acq_pkg::*;

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [SIG_W-1:0] mon_q, mon_d;
  logic [SIG_W-1:0] sen_q, sen_d;
  logic [SIG_W*TEST_W-1:0] test_q, test_d;
  logic [ADV_W-1:0] adv_q, adv_d;
  logic [TRIG_W-1:0] trig_q, trig_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;

  logic [SIG_W-1:0] prev_q, prev_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic gap_q, gap_d;
  logic trig_hit_q, trig_hit_d;

  logic setup, wr_en, mapped;
  logic [31:0] rd_val;
  mode_t mode_eff;
  logic seg_on, disc_en;
  logic accept, changed, cond_hit, store, push, disc_tag;
  logic trig_match;
  logic [BUF_W-1:0] buf_out;

  // Register bus: zero wait states, read data captured in the setup cycle
  assign setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pwrite_in && !pslverr_q;
  assign pready_out = 1'b1;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q && psel_in && penable_in;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr_in)
      CTRL_OFF: rd_val = 32'(ctrl_q);
      MON_OFF: rd_val = 32'(mon_q);
      SEN_OFF: rd_val = 32'(sen_q);
      TEST_OFF: rd_val = 32'(test_q);
      ADV_OFF: rd_val = 32'(adv_q);
      TRIG_OFF: rd_val = 32'(trig_q);
      STAT_OFF: rd_val = 32'(addr_q) | (32'(gap_q) << STAT_GAP_BIT);
      default: begin
        rd_val = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      prdata_d = pwrite_in ? 32'h00000000 : rd_val;
      pslverr_d = !mapped || (pwrite_in && paddr_in == STAT_OFF);
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    mon_d = mon_q;
    sen_d = sen_q;
    test_d = test_q;
    adv_d = adv_q;
    trig_d = trig_q;
    if (wr_en) begin
      unique case (paddr_in)
        CTRL_OFF: ctrl_d = pwdata_in[CTRL_W-1:0];
        MON_OFF: mon_d = pwdata_in[SIG_W-1:0];
        SEN_OFF: sen_d = pwdata_in[SIG_W-1:0];
        TEST_OFF: test_d = pwdata_in[SIG_W*TEST_W-1:0];
        ADV_OFF: adv_d = pwdata_in[ADV_W-1:0];
        TRIG_OFF: trig_d = pwdata_in[TRIG_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RST;
      mon_q <= MON_RST;
      sen_q <= SEN_RST;
      test_q <= TEST_RST;
      adv_q <= ADV_RST;
      trig_q <= TRIG_RST;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mon_q <= mon_d;
      sen_q <= sen_d;
      test_q <= test_d;
      adv_q <= adv_d;
      trig_q <= trig_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Store decision
  assign seg_on = ctrl_q[CTRL_SEG_BIT];
  assign disc_en = ctrl_q[CTRL_DISC_BIT];
  assign mode_eff = seg_on ? MODE_CONT : mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign accept = sample_valid_in && sample_ready_out;
  assign changed = |((sample_in ^ prev_q) & mon_q);

  cond_eval u_cond (
    .sample_in(sample_in),
    .prev_in(prev_q),
    .store_en_in(sen_q),
    .tests_in(test_q),
    .cond_type_in(cond_t'(ctrl_q[CTRL_CT_LSB +: 2])),
    .adv_value_in(adv_q[SIG_W-1:0]),
    .adv_op_in(relop_t'(adv_q[ADV_OP_LSB +: 3])),
    .hit_out(cond_hit)
  );

  always_comb begin
    unique case (mode_eff)
      MODE_CONT: store = 1'b1;
      MODE_INPUT: store = qual_in;
      MODE_TRANS: store = changed;
      MODE_COND: store = cond_hit;
    endcase
  end

  assign push = accept && store;
  assign disc_tag = disc_en && gap_q;
  assign trig_match = ((sample_in ^ trig_q[TRIG_VAL_LSB +: SIG_W]) & trig_q[SIG_W-1:0]) == '0;

  always_comb begin
    prev_d = accept ? sample_in : prev_q;
    addr_d = push ? addr_q + 1'b1 : addr_q;
    gap_d = gap_q;
    if (accept) begin
      gap_d = !store;
    end
    trig_hit_d = accept && trig_match;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prev_q <= '0;
      addr_q <= '0;
      gap_q <= 1'b0;
      trig_hit_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      addr_q <= addr_d;
      gap_q <= gap_d;
      trig_hit_q <= trig_hit_d;
    end
  end

  assign trigger_out = trig_hit_q;

  acq_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(sample_valid_in && store),
    .in_ready_out(sample_ready_out),
    .in_data_in({disc_tag, addr_q, sample_in}),
    .out_valid_out(mem_valid_out),
    .out_ready_in(mem_ready_in),
    .out_data_out(buf_out)
  );

  assign mem_data_out = buf_out[SIG_W-1:0];
  assign mem_addr_out = buf_out[SIG_W +: ADDR_W];
  assign mem_disc_out = buf_out[BUF_W-1];

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_prev;
    accept |=> prev_q == $past(sample_in);
  endproperty
  a_prev: assert property (p_prev) else $error("Previous sample not held");

  property p_trans_quiet;
    accept && mode_eff == MODE_TRANS && ((sample_in ^ prev_q) & mon_q) == '0 |-> !push;
  endproperty
  a_trans_quiet: assert property (p_trans_quiet) else $error("Store without change");

  property p_trans_change;
    accept && mode_eff == MODE_TRANS && sample_in[0] != prev_q[0] && mon_q[0] |-> push;
  endproperty
  a_trans_change: assert property (p_trans_change) else $error("Change not stored");

  property p_cond;
    accept && mode_eff == MODE_COND |-> push == cond_hit;
  endproperty
  a_cond: assert property (p_cond) else $error("Condition and store disagree");

  property p_no_enabled;
    accept && mode_eff == MODE_COND && sen_q == '0 && ctrl_q[CTRL_CT_LSB +: 2] == 2'h1
      |-> !push;
  endproperty
  a_no_enabled: assert property (p_no_enabled) else $error("Disabled signal stored");

  property p_cont;
    accept && mode_eff == MODE_CONT |-> push;
  endproperty
  a_cont: assert property (p_cont) else $error("Continuous sample dropped");

  property p_input;
    accept && mode_eff == MODE_INPUT |-> push == qual_in;
  endproperty
  a_input: assert property (p_input) else $error("Qualifier input not followed");

  property p_addr;
    push |=> addr_q == $past(addr_q) + 1'b1;
  endproperty
  a_addr: assert property (p_addr) else $error("Address not advanced");

  property p_addr_hold;
    !push |=> $stable(addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Address moved on suppress");

  sequence s_drop_then_store;
    accept && !push && disc_en ##1 push && disc_en;
  endsequence
  property p_disc;
    s_drop_then_store |-> disc_tag;
  endproperty
  a_disc: assert property (p_disc) else $error("Discontinuity not marked");

  property p_trig;
    accept && trig_match && !push |=> trigger_out;
  endproperty
  a_trig: assert property (p_trig) else $error("Trigger lost on suppress");

  property p_seg;
    seg_on && accept |-> push;
  endproperty
  a_seg: assert property (p_seg) else $error("Segmented buffer filtered");

  c_trans_drop: cover property (accept && mode_eff == MODE_TRANS && !push);
  c_disc: cover property (push && disc_tag);
  c_stall: cover property (sample_valid_in && !sample_ready_out);
  c_adv: cover property (push && mode_eff == MODE_COND && ctrl_q[CTRL_CT_LSB +: 2] == 2'h2);
endmodule

//--- logic/acq_pkg.sv
package acq_pkg;
  localparam int SIG_W = 8;
  localparam int ADDR_W = 10;
  localparam int TEST_W = 3;
  localparam int BUF_W = 1 + ADDR_W + SIG_W;
  localparam int BUF_DEPTH = 2;
  localparam int APB_AW = 8;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] MON_OFF = 8'h04;
  localparam logic [7:0] SEN_OFF = 8'h08;
  localparam logic [7:0] TEST_OFF = 8'h0C;
  localparam logic [7:0] ADV_OFF = 8'h10;
  localparam logic [7:0] TRIG_OFF = 8'h14;
  localparam logic [7:0] STAT_OFF = 8'h18;

  localparam int CTRL_W = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CT_LSB = 2;
  localparam int CTRL_DISC_BIT = 4;
  localparam int CTRL_SEG_BIT = 5;
  localparam int ADV_W = 11;
  localparam int ADV_OP_LSB = 8;
  localparam int TRIG_W = 16;
  localparam int TRIG_VAL_LSB = 8;
  localparam int STAT_GAP_BIT = 16;

  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [SIG_W-1:0] MON_RST = 8'hFF;
  localparam logic [SIG_W-1:0] SEN_RST = 8'hFF;
  localparam logic [SIG_W*TEST_W-1:0] TEST_RST = 24'h000000;
  localparam logic [ADV_W-1:0] ADV_RST = 11'h000;
  localparam logic [TRIG_W-1:0] TRIG_RST = 16'h0000;

  typedef enum logic [1:0] {MODE_CONT, MODE_INPUT, MODE_TRANS, MODE_COND} mode_t;
  typedef enum logic [1:0] {CT_AND, CT_OR, CT_ADV} cond_t;
  typedef enum logic [2:0] {T_IGNORE, T_LOW, T_HIGH, T_FALL, T_RISE, T_EDGE} test_t;
  typedef enum logic [2:0] {OP_EQ, OP_NE, OP_LT, OP_GT, OP_LE, OP_GE} relop_t;
endpackage

//--- logic/acq_buffer.sv
`timescale 1ns/1ns
module acq_buffer #(
  parameter int WIDTH = acq_pkg::BUF_W,
  parameter int DEPTH = acq_pkg::BUF_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import acq_pkg::*;
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_out = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge clock_in) begin
    mem_q <= mem_d;
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_hold_out;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("Buffer output changed while stalled");
endmodule

//--- logic/cond_eval.sv
`timescale 1ns/1ns
module cond_eval (
  input wire logic [acq_pkg::SIG_W-1:0] sample_in,
  input wire logic [acq_pkg::SIG_W-1:0] prev_in,
  input wire logic [acq_pkg::SIG_W-1:0] store_en_in,
  input wire logic [acq_pkg::SIG_W*acq_pkg::TEST_W-1:0] tests_in,
  input wire acq_pkg::cond_t cond_type_in,
  input wire logic [acq_pkg::SIG_W-1:0] adv_value_in,
  input wire acq_pkg::relop_t adv_op_in,
  output logic hit_out
);
  import acq_pkg::*;

  logic [SIG_W-1:0] pass, active, masked, refv;
  logic and_ok, or_ok, adv_ok;

  for (genvar i = 0; i < SIG_W; i++) begin : g_sig
    test_t t;
    assign t = test_t'(tests_in[i*TEST_W +: TEST_W]);
    assign active[i] = store_en_in[i] && (t != T_IGNORE);
    always_comb begin
      unique case (t)
        T_LOW: pass[i] = !sample_in[i];
        T_HIGH: pass[i] = sample_in[i];
        T_FALL: pass[i] = prev_in[i] && !sample_in[i];
        T_RISE: pass[i] = !prev_in[i] && sample_in[i];
        T_EDGE: pass[i] = prev_in[i] ^ sample_in[i];
        default: pass[i] = 1'b1;
      endcase
    end
  end

  assign and_ok = &(pass | ~active);
  assign or_ok = |(pass & active);
  assign masked = sample_in & store_en_in;
  assign refv = adv_value_in & store_en_in;

  always_comb begin
    unique case (adv_op_in)
      OP_EQ: adv_ok = (masked == refv);
      OP_NE: adv_ok = (masked != refv);
      OP_LT: adv_ok = (masked < refv);
      OP_GT: adv_ok = (masked > refv);
      OP_LE: adv_ok = (masked <= refv);
      OP_GE: adv_ok = (masked >= refv);
      default: adv_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (cond_type_in)
      CT_OR: hit_out = or_ok;
      CT_ADV: hit_out = adv_ok;
      default: hit_out = and_ok;
    endcase
  end
endmodule

//--- verif/mem_sink.sv
`timescale 1ns/1ns
module mem_sink (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic stall_in,
  output logic mem_ready_out
);
  // Memory side: takes words at a random pace, none while stalled
  initial mem_ready_out = 1'b0;
  always @(posedge clock_in) begin
    if (rst_in || stall_in) begin
      mem_ready_out <= 1'b0;
    end else begin
      mem_ready_out <= ($urandom % 3) != 0;
    end
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import acq_pkg::*;
  logic clock_in = 0;
  logic rst_in = 1;
  logic psel = 0, penable = 0, pwrite = 0, sv = 0, qual = 0, stall = 0;
  logic pready, pslverr, sready, trig, mv, mr, disc;
  logic [7:0] paddr = 8'h00, smp = 8'h00, mdata, prev;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [9:0] maddr, addr;
  logic err;
  int num_errors = 0, checked = 0, refused = 0;
  bit run = 0, acc = 0, tp = 0, gap = 0;
  logic [31:0] cfg [7];
  logic [31:0] msk [7] = '{32'h3F, 32'hFF, 32'hFF, 32'hFFFFFF, 32'h7FF, 32'hFFFF, 32'h0};
  logic [31:0] rst_v [7];
  logic [18:0] expq [$];

  acq_qualifier u_acq_qualifier (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sample_valid_in(sv),
    .sample_in(smp), .sample_ready_out(sready), .qual_in(qual), .trigger_out(trig),
    .mem_valid_out(mv), .mem_ready_in(mr), .mem_addr_out(maddr), .mem_data_out(mdata),
    .mem_disc_out(disc));
  mem_sink u_mem_sink (.clock_in(clock_in), .rst_in(rst_in), .stall_in(stall), .mem_ready_out(mr));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  task close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk_reg(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_word(string n, logic [18:0] e, logic [18:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_bit(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask

  task apb(bit wr, logic [7:0] a, logic [31:0] d);
    @(posedge clock_in);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wreg(int i, logic [31:0] d);
    apb(1, 8'(i * 4), d);
    cfg[i] = d & msk[i];
    apb(0, 8'(i * 4), 32'h0);
    chk_reg("readback", cfg[i], rd);
  endtask

  function bit tst(logic [2:0] t, bit s, bit p);
    case (t)
      1: return !s;
      2: return s;
      3: return p & !s;
      4: return !p & s;
      5: return p ^ s;
      default: return 0;
    endcase
  endfunction

  function bit cmp(logic [7:0] a, logic [7:0] b, logic [2:0] op);
    case (op)
      0: return a == b;
      1: return a != b;
      2: return a < b;
      3: return a > b;
      4: return a <= b;
      5: return a >= b;
      default: return 0;
    endcase
  endfunction

  function bit store(logic [7:0] s, logic [7:0] p, bit q);
    bit all_ok, any_ok;
    logic [2:0] t;
    all_ok = 1;
    any_ok = 0;
    for (int i = 0; i < 8; i++) begin
      t = cfg[3][3*i +: 3];
      if (cfg[2][i] && t >= 1 && t <= 5) begin
        all_ok &= tst(t, s[i], p[i]);
        any_ok |= tst(t, s[i], p[i]);
      end
    end
    if (cfg[0][5] || cfg[0][1:0] == 0) return 1;
    if (cfg[0][1:0] == 1) return q;
    if (cfg[0][1:0] == 2) return ((s ^ p) & cfg[1][7:0]) != 0;
    if (cfg[0][3:2] == 1) return any_ok;
    if (cfg[0][3:2] == 2) return cmp(s & cfg[2][7:0], cfg[4][7:0] & cfg[2][7:0], cfg[4][10:8]);
    return all_ok;
  endfunction

  always @(posedge clock_in) begin
    if (!sv || acc) begin
      sv <= run && ($urandom % 4 != 0);
      smp <= 8'($urandom);
      qual <= 1'($urandom);
    end
  end

  always @(negedge clock_in) begin
    if (rst_in) begin
      prev = 0;
      addr = 0;
      gap = 0;
      tp = 0;
      acc = 0;
    end else begin
      chk_bit("trigger", tp, trig);
      if (mv && mr) begin
        chk_word("word", expq.size() ? expq.pop_front() : 19'h7FFFF, {disc, maddr, mdata});
      end
      acc = sv && sready;
      if (sv && !sready) refused++;
      tp = acc && (((smp ^ cfg[5][15:8]) & cfg[5][7:0]) == 0);
      if (acc) begin
        if (store(smp, prev, qual)) begin
          expq.push_back({gap && cfg[0][4], addr, smp});
          addr++;
          gap = 0;
        end else begin
          gap = 1;
        end
        prev = smp;
      end
    end
  end

  task phase(logic [31:0] c, logic [31:0] m, logic [31:0] s, logic [31:0] t, logic [31:0] v);
    run = 0;
    while (sv) @(negedge clock_in);
    wreg(0, c);
    wreg(1, m);
    wreg(2, s);
    wreg(3, t);
    wreg(4, v);
    run = 1;
    repeat (60) @(posedge clock_in);
  endtask

  initial begin
    #1000000;
    num_errors++;
    close_out();
  end

  initial begin
    rst_v = '{32'(CTRL_RST), 32'(MON_RST), 32'(SEN_RST), 32'(TEST_RST), 32'(ADV_RST),
      32'(TRIG_RST), 32'h0};
    cfg = rst_v;
    void'($urandom(76));
    repeat (3) @(posedge clock_in);
    rst_in <= 0;
    for (int i = 0; i < 7; i++) begin
      apb(0, 8'(i * 4), 32'h0);
      chk_reg("reset value", rst_v[i], rd);
      chk_bit("error", 1'b0, err);
    end
    apb(0, 8'h1C, 32'h0);
    chk_reg("unmapped", 32'h0, rd);
    chk_bit("error", 1'b1, err);
    apb(1, STAT_OFF, 32'hFFFFFFFF);
    chk_bit("error", 1'b1, err);
    wreg(5, 32'h5A0F);
    phase(32'h00, 32'hFF, 32'hFF, 32'h0, 32'h0);
    stall <= 1;
    repeat (12) @(posedge clock_in);
    stall <= 0;
    chk_bit("refused", 1'b1, refused != 0);
    phase(32'h01, 32'hFF, 32'hFF, 32'h0, 32'h0);
    phase(32'h11, 32'hFF, 32'hFF, 32'h0, 32'h0);
    phase(32'h12, 32'h01, 32'hFF, 32'h0, 32'h0);
    phase(32'h23, 32'hFF, 32'hFF, 32'h480000, 32'h0);
    phase(32'h03, 32'hFF, 32'hFF, 32'h480000, 32'h0);
    phase(32'h13, 32'hFF, 32'h7F, 32'h480000, 32'h0);
    phase(32'h07, 32'hFF, 32'hFF, 32'h00A4688, 32'h0);
    phase(32'h0F, 32'hFF, 32'hFF, 32'h480000, 32'h0);
    for (int op = 0; op < 8; op++) begin
      phase(32'h0B, 32'hFF, $urandom, 32'h0, (op << 8) | 32'($urandom % 256));
    end
    repeat (6) begin
      phase($urandom, $urandom, $urandom, $urandom, $urandom);
    end
    run = 0;
    for (int i = 0; i < 300 && (sv || expq.size() != 0); i++) @(negedge clock_in);
    chk_bit("drained", 1'b1, expq.size() == 0);
    apb(0, STAT_OFF, 32'h0);
    chk_reg("status", (32'(gap) << STAT_GAP_BIT) | 32'(addr), rd);
    close_out();
  end
endmodule
